// ---- hw/sfp_pkg.sv ----
/*
 * Constants for the serial flash pin front end: sampling depth,
 * counter widths, power and protection encodings.
 * Assumes a single system clock domain that samples all link pins.
 */
package sfp_pkg;
    localparam int SYNC_STAGES   = 2;
    localparam int BIT_CNT_W     = 3;
    localparam int BYTE_CNT_W    = 16;
    localparam int PROT_W        = 3;
    localparam logic [2:0] PROT_RESET = 3'h0;
    localparam logic       LOCK_RESET = 1'h0;
    localparam logic [2:0] BIT_LAST   = 3'h7;

    typedef enum logic [1:0] {
        SFP_PWR_STANDBY = 2'b00,
        SFP_PWR_ACTIVE  = 2'b01,
        SFP_PWR_BUSY    = 2'b10
    } sfp_pwr_t;
endpackage

// ---- hw/sfp_sync.sv ----
/*
 * Two-flop synchroniser for a vector of asynchronous pins.
 * Assumes the pins are quasi-static relative to i_mclk.
 */
`timescale 1ns/1ps
`default_nettype none
module sfp_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    input  wire logic         i_mclk,
    input  wire logic         i_reset,
    input  wire logic         i_ce,
    input  wire logic [W-1:0] i_async,
    output logic      [W-1:0] o_sync
);
    logic [W-1:0] meta;
    logic [W-1:0] next_meta;
    logic [W-1:0] next_sync;

    always_comb
    begin
        next_meta = i_ce ? i_async : meta;
        next_sync = i_ce ? meta : o_sync;
    end

    always_ff @(posedge i_mclk or posedge i_reset)
    begin
        if (i_reset)
        begin
            meta   <= INIT;
            o_sync <= INIT;
        end
        else
        begin
            meta   <= next_meta;
            o_sync <= next_sync;
        end
    end
endmodule
`default_nettype wire

// ---- hw/sfp_front.sv ----
/*
 * Serial flash pin front end: samples the link pins with i_mclk,
 * shifts command bytes in, shifts reply bits out, handles select,
 * pause and write-protect freeze of the protect field.
 * Assumes the command decoder sits outside and the link clock is
 * much slower than i_mclk (link 800 ns, i_mclk 100 ns).
 */
`timescale 1ns/1ps
`default_nettype none
module sfp_front (
    input  wire logic                          i_mclk,
    input  wire logic                          i_reset,
    input  wire logic                          i_ce,
    input  wire logic                          i_serial_clk,
    input  wire logic                          i_chip_select_n,
    input  wire logic                          i_serial_data_in,
    input  wire logic                          i_pause_n,
    input  wire logic                          i_write_protect_n,
    input  wire logic                          i_cycle_busy,
    input  wire logic                          i_tx_bit,
    input  wire logic                          i_tx_enable,
    input  wire logic                          i_status_write,
    input  wire logic [sfp_pkg::PROT_W-1:0]    i_status_prot,
    input  wire logic                          i_status_lock,
    output logic                               o_serial_data_out,
    output logic                               o_serial_data_out_oe,
    output logic [7:0]                         o_rx_byte,
    output logic                               o_rx_valid,
    output logic                               o_tx_next,
    output logic [sfp_pkg::BYTE_CNT_W-1:0]     o_byte_count,
    output logic                               o_cmd_start,
    output logic                               o_cmd_end,
    output logic                               o_armed,
    output logic                               o_paused,
    output sfp_pkg::sfp_pwr_t                  o_power_mode,
    output logic                               o_protect_size_bit2,
    output logic                               o_protect_size_bit1,
    output logic                               o_protect_size_bit0,
    output logic                               o_status_write_lock
);
    logic [3:0] pins_s;
    logic       sclk;
    logic       csn;
    logic       sdi;
    logic       pausen;

    // Select starts low: a pin held low since power-up must not look like a fall
    sfp_sync #(.W(4), .INIT(4'h3)) u_sync (
        .i_mclk  (i_mclk),
        .i_reset (i_reset),
        .i_ce    (i_ce),
        .i_async ({i_serial_clk, i_chip_select_n, i_serial_data_in, i_pause_n}),
        .o_sync  (pins_s)
    );
    assign sclk   = pins_s[3];
    assign csn    = pins_s[2];
    assign sdi    = pins_s[1];
    assign pausen = pins_s[0];

    logic wp_m;
    logic wp_n;
    always_ff @(posedge i_mclk or posedge i_reset)
    begin
        if (i_reset)
        begin
            wp_m <= 1'b1;
            wp_n <= 1'b1;
        end
        else if (i_ce)
        begin
            wp_m <= i_write_protect_n;
            wp_n <= wp_m;
        end
    end

    // Edge history of synchronised pins
    logic sclk_d;
    logic csn_d;
    logic sclk_rise;
    logic sclk_fall;
    logic cs_fall;
    logic cs_rise;
    logic pause_now;
    assign sclk_rise = sclk & ~sclk_d;
    assign sclk_fall = ~sclk & sclk_d;
    assign cs_fall   = ~csn & csn_d;
    assign cs_rise   = csn & ~csn_d;

    // Pause taken only while selected; releases when pin returns high
    logic paused;
    logic next_paused;
    assign pause_now = paused | next_paused;

    // Link state
    logic [sfp_pkg::BIT_CNT_W-1:0]  bit_cnt;
    logic [7:0]                     shreg;
    logic [sfp_pkg::BYTE_CNT_W-1:0] byte_cnt;
    logic                           armed;
    logic                           sdo;
    logic                           sdo_oe;
    logic                           rx_valid;
    logic                           tx_next;
    logic                           cmd_start;
    logic                           cmd_end;
    logic [7:0]                     rx_byte;
    sfp_pkg::sfp_pwr_t              pwr;
    logic [sfp_pkg::PROT_W-1:0]     prot;
    logic                           lock;

    logic [sfp_pkg::BIT_CNT_W-1:0]  next_bit_cnt;
    logic [7:0]                     next_shreg;
    logic [sfp_pkg::BYTE_CNT_W-1:0] next_byte_cnt;
    logic                           next_armed;
    logic                           next_sdo;
    logic                           next_sdo_oe;
    logic                           next_rx_valid;
    logic                           next_tx_next;
    logic                           next_cmd_start;
    logic                           next_cmd_end;
    logic [7:0]                     next_rx_byte;
    sfp_pkg::sfp_pwr_t              next_pwr;
    logic [sfp_pkg::PROT_W-1:0]     next_prot;
    logic                           next_lock;

    always_comb
    begin
        next_paused    = paused;
        next_bit_cnt   = bit_cnt;
        next_shreg     = shreg;
        next_byte_cnt  = byte_cnt;
        next_armed     = armed;
        next_sdo       = sdo;
        next_sdo_oe    = sdo_oe;
        next_rx_valid  = 1'b0;
        next_tx_next   = 1'b0;
        next_cmd_start = 1'b0;
        next_cmd_end   = 1'b0;
        next_rx_byte   = rx_byte;
        next_prot      = prot;
        next_lock      = lock;

        if (csn)
            next_paused = 1'b0;
        else if (!pausen)
            next_paused = 1'b1;
        else
            next_paused = 1'b0;

        if (cs_fall)
        begin
            next_armed     = 1'b1;
            next_cmd_start = 1'b1;
        end

        if (cs_rise)
        begin
            // Partial bytes discarded; count is already zero when o_cmd_end pulses
            next_bit_cnt  = '0;
            next_byte_cnt = '0;
            next_cmd_end  = armed;
        end
        else if (!csn && armed && !pause_now)
        begin
            // Edges seen while paused are dropped, so the clock may toggle freely
            if (sclk_rise)
            begin
                next_shreg   = {shreg[6:0], sdi};
                next_bit_cnt = bit_cnt + 3'h1;
                if (bit_cnt == sfp_pkg::BIT_LAST)
                begin
                    next_rx_byte  = {shreg[6:0], sdi};
                    next_rx_valid = 1'b1;
                    next_byte_cnt = byte_cnt + 16'h0001;
                end
            end
            if (sclk_fall)
            begin
                next_sdo     = i_tx_bit;
                next_tx_next = 1'b1;
            end
        end

        next_sdo_oe = !csn && !pause_now && armed && i_tx_enable;

        if (!csn)
            next_pwr = sfp_pkg::SFP_PWR_ACTIVE;
        else if (i_cycle_busy)
            next_pwr = sfp_pkg::SFP_PWR_BUSY;
        else
            next_pwr = sfp_pkg::SFP_PWR_STANDBY;

        // Protect field and lock held while write protect is low
        if (i_status_write && wp_n)
        begin
            next_prot = i_status_prot;
            next_lock = i_status_lock;
        end
    end

    always_ff @(posedge i_mclk or posedge i_reset)
    begin
        if (i_reset)
        begin
            sclk_d    <= 1'b0;
            csn_d     <= 1'b0;
            paused    <= 1'b0;
            bit_cnt   <= '0;
            shreg     <= 8'h00;
            byte_cnt  <= '0;
            armed     <= 1'b0;
            sdo       <= 1'b0;
            sdo_oe    <= 1'b0;
            rx_valid  <= 1'b0;
            tx_next   <= 1'b0;
            cmd_start <= 1'b0;
            cmd_end   <= 1'b0;
            rx_byte   <= 8'h00;
            pwr       <= sfp_pkg::SFP_PWR_STANDBY;
            prot      <= sfp_pkg::PROT_RESET;
            lock      <= sfp_pkg::LOCK_RESET;
        end
        else if (i_ce)
        begin
            sclk_d    <= sclk;
            csn_d     <= csn;
            paused    <= next_paused;
            bit_cnt   <= next_bit_cnt;
            shreg     <= next_shreg;
            byte_cnt  <= next_byte_cnt;
            armed     <= next_armed;
            sdo       <= next_sdo;
            sdo_oe    <= next_sdo_oe;
            rx_valid  <= next_rx_valid;
            tx_next   <= next_tx_next;
            cmd_start <= next_cmd_start;
            cmd_end   <= next_cmd_end;
            rx_byte   <= next_rx_byte;
            pwr       <= next_pwr;
            prot      <= next_prot;
            lock      <= next_lock;
        end
    end

    assign o_serial_data_out    = sdo;
    assign o_serial_data_out_oe = sdo_oe;
    assign o_rx_byte            = rx_byte;
    assign o_rx_valid           = rx_valid;
    assign o_tx_next            = tx_next;
    assign o_byte_count         = byte_cnt;
    assign o_cmd_start          = cmd_start;
    assign o_cmd_end            = cmd_end;
    assign o_armed              = armed;
    assign o_paused             = paused;
    assign o_power_mode         = pwr;
    assign o_protect_size_bit2  = prot[2];
    assign o_protect_size_bit1  = prot[1];
    assign o_protect_size_bit0  = prot[0];
    assign o_status_write_lock  = lock;
endmodule
`default_nettype wire

// ---- verif/sfp_front_monitor.sv ----
/* Checker for sfp_front: pin-to-port timing relations.
   Assumes link half periods of at least 4 i_mclk; checks rest while reset is high or i_ce is low. */
`timescale 1ns/1ps
`default_nettype none
module sfp_front_monitor (
    input wire logic              i_mclk,
    input wire logic              i_reset,
    input wire logic              i_ce,
    input wire logic              i_serial_clk,
    input wire logic              i_chip_select_n,
    input wire logic              i_pause_n,
    input wire logic              i_write_protect_n,
    input wire logic              i_cycle_busy,
    input wire logic              o_serial_data_out_oe,
    input wire logic              o_rx_valid,
    input wire logic              o_tx_next,
    input wire logic [15:0]       o_byte_count,
    input wire logic              o_armed,
    input wire logic              o_paused,
    input wire sfp_pkg::sfp_pwr_t o_power_mode,
    input wire logic              o_protect_size_bit2,
    input wire logic              o_protect_size_bit1,
    input wire logic              o_protect_size_bit0,
    input wire logic              o_status_write_lock
);
    default clocking mon_cb @(posedge i_mclk);
    endclocking
    default disable iff (i_reset || !i_ce);
    // Five samples cover two sync stages plus edge detect and output flop
    a_float_deselect: assert property (i_chip_select_n [*5] |-> !o_serial_data_out_oe)
        else $error("output driven while deselected");
    a_standby_idle: assert property (
        (i_chip_select_n && !i_cycle_busy) [*5] |-> o_power_mode == sfp_pkg::SFP_PWR_STANDBY)
        else $error("not standby");
    a_busy_stays: assert property (
        (i_chip_select_n && i_cycle_busy) [*5] |-> o_power_mode == sfp_pkg::SFP_PWR_BUSY)
        else $error("busy not kept");
    a_select_active: assert property (
        (!i_chip_select_n) [*5] |-> o_power_mode == sfp_pkg::SFP_PWR_ACTIVE)
        else $error("not active");
    a_pause_quiet: assert property ((!i_pause_n && !i_chip_select_n) [*5]
        |-> o_paused && !o_serial_data_out_oe && !o_rx_valid) else $error("pause ignored");
    a_protect_frozen: assert property (!i_write_protect_n [*4] |=> $stable({
        o_protect_size_bit2, o_protect_size_bit1, o_protect_size_bit0, o_status_write_lock}))
        else $error("protect field changed");
    a_rx_after_rise: assert property (o_rx_valid |-> o_armed && $past(i_serial_clk, 2))
        else $error("byte without armed rise");
    a_tx_after_fall: assert property (o_tx_next |-> !$past(i_serial_clk, 2))
        else $error("output step without fall");
    a_end_clears: assert property ($rose(i_chip_select_n) && o_armed
        |-> ##[2:6] o_byte_count == 16'h0) else $error("count not cleared");
endmodule
bind sfp_front sfp_front_monitor sfp_front_monitor_inst (.*);
`default_nettype wire

// ---- verif/sfp_mst.sv ----
/* Link master model: drives serial clock, select, data and pause.
   Assumes the caller steps it from the falling edge of i_mclk. */
`timescale 1ns/1ps
`default_nettype none
module sfp_mst (
    input  wire logic i_mclk,
    output logic      o_sclk,
    output logic      o_cs_n,
    output logic      o_mosi,
    output logic      o_pause_n
);
    logic       cpol = 1'b0;
    initial
    begin
        o_sclk = 1'b0;
        o_cs_n = 1'b0;
        o_mosi = 1'b0;
        o_pause_n = 1'b1;
    end
    task automatic tick(input int n);
        repeat (n) @(negedge i_mclk);
    endtask
    task automatic sel(input logic pol);
        cpol = pol;
        o_sclk = pol;
        tick(4);
        o_cs_n = 1'b0;
        tick(6);
    endtask
    task automatic bits(input logic [7:0] d, input int n);
        for (int k = 7; k > 7 - n; k--)
        begin
            if (cpol)
                o_sclk = 1'b0;
            o_mosi = d[k];
            tick(4);
            o_sclk = 1'b1;
            tick(4);
            if (!cpol)
                o_sclk = 1'b0;
        end
    endtask
    // Only called while selected
    task automatic hold(input logic on);
        o_pause_n = !on;
        tick(6);
    endtask
    // Released data line: no pull, so show the inverse
    task automatic desel();
        tick(4);
        o_cs_n = 1'b1;
        o_mosi = !o_mosi;
        tick(8);
    endtask
endmodule
`default_nettype wire

// ---- verif/tb_top.sv ----
/* Self-checking bench for sfp_front with link master model.
   Assumes i_mclk 100 ns and link half period 400 ns. */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic i_mclk = 1'b0, i_reset, i_ce, i_cycle_busy, i_tx_bit = 1'b0;
    logic i_tx_enable, i_status_write, i_status_lock;
    logic i_write_protect_n, i_serial_clk, i_chip_select_n, i_serial_data_in, i_pause_n;
    logic [2:0] i_status_prot;
    logic o_serial_data_out, o_serial_data_out_oe, o_rx_valid, o_tx_next, o_cmd_start, o_cmd_end;
    logic o_armed, o_paused, o_protect_size_bit2, o_protect_size_bit1, o_protect_size_bit0;
    logic o_status_write_lock, miso_last = 1'b0;
    logic tx_exp = 1'b0, sclk_q = 1'b0, sclk_qq = 1'b0;
    logic [7:0] o_rx_byte, d, expq[$];
    logic [15:0] o_byte_count;
    logic [3:0] pexp = 4'h0;
    sfp_pkg::sfp_pwr_t o_power_mode;
    int seed = 32'hc335, fails = 0, samples_checked = 0, cycles = 0;
    int cmd_starts = 0, cmd_ends = 0;
    wire logic miso = o_serial_data_out_oe ? o_serial_data_out : !miso_last;
    sfp_front sfp_front_inst (.*);
    sfp_mst sfp_mst_inst (.i_mclk(i_mclk), .o_sclk(i_serial_clk),
        .o_cs_n(i_chip_select_n), .o_mosi(i_serial_data_in), .o_pause_n(i_pause_n));
    always #50 i_mclk = ~i_mclk;
    always @(posedge i_mclk)
    begin
        if (o_serial_data_out_oe)
            miso_last <= o_serial_data_out;
        sclk_q  <= i_serial_clk;
        sclk_qq <= sclk_q;
    end
    function automatic logic [7:0] rnd();
        return 8'($random(seed));
    endfunction
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic complete_run();
        $display("compares %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic send(input logic [7:0] b);
        expq.push_back(b);
        sfp_mst_inst.bits(b, 8);
    endtask
    always @(negedge i_mclk)
    begin
        cycles++;
        if (cycles > 20000)
        begin
            fails++;
            complete_run();
        end
        else
        begin
            if (o_rx_valid)
                check("rx_byte", o_rx_byte,
                    expq.size() ? {8'h0, expq.pop_front()} : 16'hffff);
            if (o_tx_next)
            begin
                check("data_out", o_serial_data_out, i_tx_bit);
                tx_exp <= i_tx_bit;
                i_tx_bit <= (rnd() >= 8'h80);
            end
            // Rise seen a cycle late; the output cannot move before the next fall
            if (sclk_q && !sclk_qq && o_serial_data_out_oe)
                check("miso", miso, tx_exp);
            if (o_cmd_start)
                cmd_starts++;
            if (o_cmd_end)
                cmd_ends++;
        end
    end
    initial
    begin
        i_reset = 1'b1;
        i_ce = 1'b1;
        i_cycle_busy = 1'b0;
        i_tx_enable = 1'b0;
        i_status_write = 1'b0;
        i_status_lock = 1'b0;
        i_status_prot = 3'h0;
        i_write_protect_n = 1'b1;
        repeat (12) @(negedge i_mclk);
        i_reset = 1'b0;
        i_tx_enable = 1'b1;
        // Select low since power-up, no fall seen yet
        sfp_mst_inst.bits(8'ha5, 8);
        check("armed", o_armed, 16'h0);
        check("count", o_byte_count, 16'h0);
        sfp_mst_inst.desel();
        $display("test unarmed done");
        for (int m = 0; m < 2; m++)
        begin
            sfp_mst_inst.sel(m[0]);
            check("power", o_power_mode, sfp_pkg::SFP_PWR_ACTIVE);
            repeat (3) send(rnd());
            sfp_mst_inst.tick(4);
            check("count", o_byte_count, 16'h3);
            sfp_mst_inst.bits(rnd(), 5);
            sfp_mst_inst.desel();
            check("oe", o_serial_data_out_oe, 16'h0);
            check("count", o_byte_count, 16'h0);
            $display("test mode %0d done", m);
        end
        sfp_mst_inst.sel(1'b0);
        d = rnd();
        expq.push_back(d);
        sfp_mst_inst.bits(d, 4);
        sfp_mst_inst.hold(1'b1);
        check("paused", o_paused, 16'h1);
        check("oe", o_serial_data_out_oe, 16'h0);
        sfp_mst_inst.bits(rnd(), 4);
        sfp_mst_inst.hold(1'b0);
        sfp_mst_inst.bits(d << 4, 4);
        sfp_mst_inst.desel();
        check("left", expq.size(), 16'h0);
        $display("test pause done");
        for (int b = 0; b < 4; b++)
        begin
            i_cycle_busy = (rnd() >= 8'h80);
            sfp_mst_inst.tick(6);
            check("power", o_power_mode, i_cycle_busy ? sfp_pkg::SFP_PWR_BUSY
                : sfp_pkg::SFP_PWR_STANDBY);
        end
        $display("test power done");
        for (int w = 0; w < 4; w++)
        begin
            i_write_protect_n = w[0];
            sfp_mst_inst.tick(4);
            d = rnd();
            pexp = w[0] ? d[3:0] : pexp;
            {i_status_prot, i_status_lock} = d[3:0];
            i_status_write = 1'b1;
            sfp_mst_inst.tick(1);
            i_status_write = 1'b0;
            sfp_mst_inst.tick(2);
            check("protect", {o_protect_size_bit2, o_protect_size_bit1, o_protect_size_bit0,
                o_status_write_lock}, pexp);
        end
        $display("test protect done");
        // Write strobe while the enable is low must not land
        i_ce = 1'b0;
        {i_status_prot, i_status_lock} = ~pexp;
        i_status_write = 1'b1;
        sfp_mst_inst.tick(2);
        i_status_write = 1'b0;
        i_ce = 1'b1;
        sfp_mst_inst.tick(2);
        check("frozen", {o_protect_size_bit2, o_protect_size_bit1, o_protect_size_bit0,
            o_status_write_lock}, pexp);
        $display("test enable done");
        check("starts", cmd_starts, 16'h3);
        check("ends", cmd_ends, 16'h3);
        complete_run();
    end
endmodule
`default_nettype wire
